// ===== efcui_pkg.sv
// constants for the flash command front end: offsets, fields, codes, timing
// assumes a 32-bit register bus that decodes the low address byte only
package efcui_pkg;
    // -----------------------------------------------------------------
    // register offsets inside the memory controller window
    // -----------------------------------------------------------------
    localparam logic [31:0] MC_BASE = 32'hFFFFFF00;
    localparam logic [7:0] OFF_MODE = 8'h60;
    localparam logic [7:0] OFF_CMD = 8'h64;
    localparam logic [7:0] OFF_STAT = 8'h68;
    localparam logic [7:0] OFF_RSVD = 8'h6C;
    // -----------------------------------------------------------------
    // mode register fields
    // -----------------------------------------------------------------
    localparam int MB_RDY_IE = 0;
    localparam int MB_LOCKED_WRITE_ERROR_IE = 2;
    localparam int MB_BAD_COMMAND_ERROR_IE = 3;
    localparam int MB_SKIP_ERASE = 7;
    localparam int FWS_LSB = 8;
    localparam int MICROSECOND_CYCLES_LSB = 16;
    localparam logic [31:0] MODE_WMASK = 32'h00FF038D;
    localparam logic [31:0] MODE_RESET = 32'h00000000;
    // -----------------------------------------------------------------
    // command register fields and codes
    // -----------------------------------------------------------------
    localparam int KEY_LSB = 24;
    localparam logic [7:0] CMD_KEY = 8'h5A;
    localparam int PAGE_LSB = 8;
    localparam int PAGE_W = 10;
    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_WRITE_PAGE = 4'h1;
    localparam logic [3:0] CMD_LOCK = 4'h2;
    localparam logic [3:0] CMD_WRITE_LOCK = 4'h3;
    localparam logic [3:0] CMD_UNLOCK = 4'h4;
    localparam logic [3:0] CMD_ERASE_ALL = 4'h8;
    localparam logic [3:0] CMD_NVM_SET = 4'hB;
    localparam logic [3:0] CMD_NVM_CLR = 4'hD;
    localparam logic [3:0] CMD_SECURE = 4'hF;
    // -----------------------------------------------------------------
    // status bits, access timing, bus answers
    // -----------------------------------------------------------------
    localparam int SB_READY = 0;
    localparam int SB_LOCKED_WRITE_ERROR = 2;
    localparam int SB_BAD_COMMAND_ERROR = 3;
    localparam int SB_SEC = 4;
    localparam int SB_NVM_LSB = 8;
    localparam int SB_LOCK_LSB = 16;
    localparam logic [2:0] RD_BASE = 3'h1;
    localparam logic [2:0] WR_BASE = 3'h2;
    localparam logic [2:0] WR_MAX = 3'h4;
    localparam int UNIT_TICKS = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {OP_PROG, OP_LOCK, OP_UNLOCK, OP_ERASE,
        OP_NVM_SET, OP_NVM_CLR, OP_SECURE} efcui_op_t;
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_RUN_THEN_LOCK} efcui_fsm_t;
endpackage

// ===== efcui_op_if.sv
// handshake between command decoder and operation timer
// assumes both ends run on the same clock
`timescale 1ns/1ns
`default_nettype none
interface efcui_op_if;
    logic start;
    logic [2:0] units;
    logic [7:0] tick_len;
    logic done;
    logic busy;
    modport ctl (output start, output units, output tick_len, input done, input busy);
    modport seq (input start, input units, input tick_len, output done, output busy);
endinterface
`default_nettype wire

// ===== efcui_seq.sv
// operation timer: counts flash operation time in microsecond ticks
// assumes start only while not busy; one clock, synchronous reset
`timescale 1ns/1ns
`default_nettype none
module efcui_seq #(
    parameter int UNIT_TICKS = efcui_pkg::UNIT_TICKS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    efcui_op_if.seq op
);
    typedef struct packed {
        logic busy;
        logic done;
        logic [15:0] ticks;
        logic [7:0] cyc;
        logic [7:0] len;
    } efcui_seq_st_t;

    efcui_seq_st_t st_r;
    efcui_seq_st_t st_nxt;

    // -----------------------------------------------------------------
    // tick counting
    // -----------------------------------------------------------------
    // one tick lasts tick_len+1 cycles, one unit lasts UNIT_TICKS ticks
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (!st_r.busy && op.start) begin
            st_nxt.busy = 1'b1;
            st_nxt.ticks = 16'(op.units * UNIT_TICKS);
            st_nxt.cyc = 8'h00;
            st_nxt.len = op.tick_len;
        end else if (st_r.busy) begin
            if (st_r.cyc >= st_r.len) begin
                st_nxt.cyc = 8'h00;
                st_nxt.ticks = st_r.ticks - 16'h0001;
                if (st_r.ticks <= 16'h0001) begin
                    st_nxt.busy = 1'b0;
                    st_nxt.done = 1'b1;
                end
            end else begin
                st_nxt.cyc = st_r.cyc + 8'h01;
            end
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign op.busy = st_r.busy;
    assign op.done = st_r.done;
endmodule
`default_nettype wire

// ===== efcui_top.sv
// flash command front end: mode, keyed command and status registers
// assumes an AXI4-Lite master on aclk; flash array timing is emulated
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module efcui_top #(
    parameter int REG_N = 16,
    parameter int NVM_N = 2,
    parameter int UNIT_TICKS = efcui_pkg::UNIT_TICKS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq,
    output logic [2:0] read_wait_cycles,
    output logic [2:0] write_wait_cycles,
    output logic [NVM_N-1:0] nvm_bits,
    output logic security_active
);
    localparam int RIDX_W = $clog2(REG_N);
    localparam int PW = efcui_pkg::PAGE_W;

    typedef struct packed {
        logic aw_v;
        logic [7:0] aw_a;
        logic w_v;
        logic [31:0] w_d;
        logic [3:0] w_s;
        logic b_v;
        logic [1:0] b_r;
        logic r_v;
        logic [31:0] r_d;
        logic [1:0] r_r;
        logic [31:0] mode;
        logic ready;
        logic locked_write_error;
        logic bad_command_error;
        logic secure;
        logic [NVM_N-1:0] nvm;
        logic [REG_N-1:0] locks;
        efcui_pkg::efcui_fsm_t fsm;
        efcui_pkg::efcui_op_t op;
        logic [PW-1:0] page;
        logic start;
    } efcui_st_t;

    efcui_st_t st_r;
    efcui_st_t st_nxt;
    efcui_op_if op_if ();

    logic wr_fire;
    logic rd_fire;
    logic [7:0] key;
    logic [3:0] code;
    logic [PW-1:0] pg;
    logic [31:0] stat;
    logic [31:0] bmask;
    logic known;

    // -----------------------------------------------------------------
    // bus handshakes and command field split
    // -----------------------------------------------------------------
    // one write and one read in flight; answers come from registers
    assign s_axi_awready = !st_r.aw_v;
    assign s_axi_wready = !st_r.w_v;
    assign s_axi_arready = !st_r.r_v;
    assign s_axi_bvalid = st_r.b_v;
    assign s_axi_bresp = st_r.b_r;
    assign s_axi_rvalid = st_r.r_v;
    assign s_axi_rdata = st_r.r_d;
    assign s_axi_rresp = st_r.r_r;
    assign wr_fire = st_r.aw_v && st_r.w_v && !st_r.b_v;
    assign rd_fire = s_axi_arvalid && !st_r.r_v;
    assign key = st_r.w_d[efcui_pkg::KEY_LSB +: 8];
    assign code = st_r.w_d[3:0];
    assign pg = st_r.w_d[efcui_pkg::PAGE_LSB +: PW];

    // byte lanes of the write, limited to writable mode bits
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            bmask[8*i +: 8] = {8{st_r.w_s[i]}};
        end
        bmask = bmask & efcui_pkg::MODE_WMASK;
    end

    // codes that name an operation or nop, the rest are reserved
    always_comb begin
        unique case (code)
            efcui_pkg::CMD_NOP, efcui_pkg::CMD_WRITE_PAGE, efcui_pkg::CMD_LOCK,
            efcui_pkg::CMD_WRITE_LOCK, efcui_pkg::CMD_UNLOCK,
            efcui_pkg::CMD_ERASE_ALL, efcui_pkg::CMD_NVM_SET,
            efcui_pkg::CMD_NVM_CLR, efcui_pkg::CMD_SECURE: known = 1'b1;
            default: known = 1'b0;
        endcase
    end

    // -----------------------------------------------------------------
    // status word
    // -----------------------------------------------------------------
    always_comb begin
        stat = 32'h00000000;
        stat[efcui_pkg::SB_READY] = st_r.ready;
        stat[efcui_pkg::SB_LOCKED_WRITE_ERROR] = st_r.locked_write_error;
        stat[efcui_pkg::SB_BAD_COMMAND_ERROR] = st_r.bad_command_error;
        stat[efcui_pkg::SB_SEC] = st_r.secure;
        stat[efcui_pkg::SB_NVM_LSB +: NVM_N] = st_r.nvm;
        stat[efcui_pkg::SB_LOCK_LSB +: REG_N] = st_r.locks;
    end

    // -----------------------------------------------------------------
    // operation timer
    // -----------------------------------------------------------------
    // program takes two units with erase, one without; erase-all two
    assign op_if.start = st_r.start;
    assign op_if.tick_len = st_r.mode[efcui_pkg::MICROSECOND_CYCLES_LSB +: 8];
    always_comb begin
        unique case (st_r.op)
            efcui_pkg::OP_PROG: op_if.units = st_r.mode[efcui_pkg::MB_SKIP_ERASE] ?
                3'h1 : 3'h2;
            efcui_pkg::OP_ERASE: op_if.units = 3'h2;
            default: op_if.units = 3'h1;
        endcase
    end

    efcui_seq #(
        .UNIT_TICKS(UNIT_TICKS)
    ) u_seq (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .op(op_if.seq)
    );

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.start = 1'b0;
        // address and data captured independently
        if (s_axi_awvalid && !st_r.aw_v) begin
            st_nxt.aw_v = 1'b1;
            st_nxt.aw_a = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_r.w_v) begin
            st_nxt.w_v = 1'b1;
            st_nxt.w_d = s_axi_wdata;
            st_nxt.w_s = s_axi_wstrb;
        end
        if (st_r.b_v && s_axi_bready) begin
            st_nxt.b_v = 1'b0;
        end
        if (st_r.r_v && s_axi_rready) begin
            st_nxt.r_v = 1'b0;
        end
        // read decode; status read clears the sticky errors
        if (rd_fire) begin
            st_nxt.r_v = 1'b1;
            st_nxt.r_r = efcui_pkg::RESP_OKAY;
            st_nxt.r_d = 32'h00000000;
            unique case (s_axi_araddr)
                efcui_pkg::OFF_MODE: st_nxt.r_d = st_r.mode;
                efcui_pkg::OFF_STAT: begin
                    st_nxt.r_d = stat;
                    st_nxt.locked_write_error = 1'b0;
                    st_nxt.bad_command_error = 1'b0;
                end
                efcui_pkg::OFF_CMD, efcui_pkg::OFF_RSVD: st_nxt.r_d = 32'h00000000;
                default: st_nxt.r_r = efcui_pkg::RESP_SLVERR;
            endcase
        end
        // operation end: apply effect or chain the lock step
        if (op_if.done) begin
            if (st_r.fsm == efcui_pkg::ST_RUN_THEN_LOCK) begin
                st_nxt.op = efcui_pkg::OP_LOCK;
                st_nxt.fsm = efcui_pkg::ST_RUN;
                st_nxt.start = 1'b1;
            end else begin
                st_nxt.fsm = efcui_pkg::ST_IDLE;
                st_nxt.ready = 1'b1;
                unique case (st_r.op)
                    efcui_pkg::OP_LOCK: st_nxt.locks[st_r.page[PW-1 -: RIDX_W]] = 1'b1;
                    efcui_pkg::OP_UNLOCK: st_nxt.locks[st_r.page[PW-1 -: RIDX_W]] = 1'b0;
                    efcui_pkg::OP_NVM_SET: begin
                        if (st_r.page < PW'(NVM_N)) begin
                            st_nxt.nvm[st_r.page[$clog2(NVM_N)-1:0]] = 1'b1;
                        end
                    end
                    efcui_pkg::OP_NVM_CLR: begin
                        if (st_r.page < PW'(NVM_N)) begin
                            st_nxt.nvm[st_r.page[$clog2(NVM_N)-1:0]] = 1'b0;
                        end
                    end
                    efcui_pkg::OP_SECURE: st_nxt.secure = 1'b1;
                    default: ;
                endcase
            end
        end
        // write decode; errors set after the read clear so set wins
        if (wr_fire) begin
            st_nxt.aw_v = 1'b0;
            st_nxt.w_v = 1'b0;
            st_nxt.b_v = 1'b1;
            st_nxt.b_r = efcui_pkg::RESP_OKAY;
            unique case (st_r.aw_a)
                efcui_pkg::OFF_MODE: st_nxt.mode = (st_r.mode & ~bmask) | (st_r.w_d & bmask);
                efcui_pkg::OFF_CMD: begin
                    if (key != efcui_pkg::CMD_KEY || !known) begin
                        st_nxt.bad_command_error = 1'b1;
                    end else if (st_r.fsm == efcui_pkg::ST_IDLE && code != efcui_pkg::CMD_NOP) begin
                        // busy controller drops the command nop does nothing
                        st_nxt.page = pg;
                        st_nxt.fsm = efcui_pkg::ST_RUN;
                        st_nxt.start = 1'b1;
                        st_nxt.ready = 1'b0;
                        unique case (code)
                            efcui_pkg::CMD_WRITE_PAGE, efcui_pkg::CMD_WRITE_LOCK: begin
                                st_nxt.op = efcui_pkg::OP_PROG;
                                if (code == efcui_pkg::CMD_WRITE_LOCK) begin
                                    st_nxt.fsm = efcui_pkg::ST_RUN_THEN_LOCK;
                                end
                                if (st_r.locks[pg[PW-1 -: RIDX_W]]) begin
                                    st_nxt.locked_write_error = 1'b1;
                                    st_nxt.fsm = efcui_pkg::ST_IDLE;
                                    st_nxt.start = 1'b0;
                                    st_nxt.ready = 1'b1;
                                end
                            end
                            efcui_pkg::CMD_LOCK: st_nxt.op = efcui_pkg::OP_LOCK;
                            efcui_pkg::CMD_UNLOCK: st_nxt.op = efcui_pkg::OP_UNLOCK;
                            efcui_pkg::CMD_ERASE_ALL: begin
                                st_nxt.op = efcui_pkg::OP_ERASE;
                                if (|st_r.locks) begin
                                    st_nxt.locked_write_error = 1'b1;
                                    st_nxt.fsm = efcui_pkg::ST_IDLE;
                                    st_nxt.start = 1'b0;
                                    st_nxt.ready = 1'b1;
                                end
                            end
                            efcui_pkg::CMD_NVM_SET: st_nxt.op = efcui_pkg::OP_NVM_SET;
                            efcui_pkg::CMD_NVM_CLR: st_nxt.op = efcui_pkg::OP_NVM_CLR;
                            default: st_nxt.op = efcui_pkg::OP_SECURE;
                        endcase
                    end
                end
                efcui_pkg::OFF_STAT, efcui_pkg::OFF_RSVD: ;
                default: st_nxt.b_r = efcui_pkg::RESP_SLVERR;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // state register
    // -----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.mode <= efcui_pkg::MODE_RESET;
            st_r.ready <= 1'b1;
            st_r.fsm <= efcui_pkg::ST_IDLE;
            st_r.op <= efcui_pkg::OP_PROG;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    // interrupt line from enabled status flags
    assign irq = (st_r.ready && st_r.mode[efcui_pkg::MB_RDY_IE]) ||
        (st_r.locked_write_error && st_r.mode[efcui_pkg::MB_LOCKED_WRITE_ERROR_IE]) ||
        (st_r.bad_command_error && st_r.mode[efcui_pkg::MB_BAD_COMMAND_ERROR_IE]);

    // flash access length from the wait field
    always_comb begin
        read_wait_cycles = {1'b0, st_r.mode[efcui_pkg::FWS_LSB +: 2]} +
            efcui_pkg::RD_BASE;
        write_wait_cycles = {1'b0, st_r.mode[efcui_pkg::FWS_LSB +: 2]} +
            efcui_pkg::WR_BASE;
        if (write_wait_cycles > efcui_pkg::WR_MAX) begin
            write_wait_cycles = efcui_pkg::WR_MAX;
        end
    end

    assign nvm_bits = st_r.nvm;
    assign security_active = st_r.secure;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);

    irq_ready_a: assert property (st_r.ready && st_r.mode[0] |-> irq)
        else $error("ready enabled but no interrupt");
    irq_quiet_a: assert property (st_r.mode[3:0] == 4'h0 |-> !irq)
        else $error("interrupt with all enables clear");
    bad_key_a: assert property (wr_fire && !op_if.done && st_r.aw_a == efcui_pkg::OFF_CMD &&
        key != efcui_pkg::CMD_KEY |=> st_r.bad_command_error && $stable(st_r.fsm))
        else $error("bad key not flagged or acted");
    nop_quiet_a: assert property (wr_fire && st_r.aw_a == 8'h64 && key == 8'h5A &&
        code == 4'h0 && st_r.ready |=> st_r.ready && !st_r.start)
        else $error("nop command started work");
    busy_ignore_a: assert property (wr_fire && !op_if.done && !st_r.ready && key == efcui_pkg::CMD_KEY
        |=> $stable(st_r.op) && $stable(st_r.page))
        else $error("command accepted while busy");
    ready_clear_a: assert property ($rose(st_r.start) && st_r.fsm != efcui_pkg::ST_IDLE ##0
        $past(st_r.ready) |-> !st_r.ready)
        else $error("ready still set after start");
    read_wait_a: assert property (read_wait_cycles == 3'(st_r.mode[9:8]) + 3'h1)
        else $error("read wait length wrong");
    write_cap_a: assert property (st_r.mode[9] |-> write_wait_cycles == 3'h4)
        else $error("write wait not capped at four");
    lock_done_a: assert property (op_if.done && st_r.op == efcui_pkg::OP_LOCK &&
        st_r.fsm == efcui_pkg::ST_RUN |=> st_r.locks[st_r.page[PW-1 -: RIDX_W]])
        else $error("region not locked after lock step");
endmodule
`default_nettype wire

// ===== efcui_cpu_model.sv
// processor-side model: one AXI4-Lite write and one read at a time
// assumes tasks are called from one bench process clocked on aclk
`timescale 1ns/1ns
`default_nettype none
module efcui_cpu_model (
    input wire logic aclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    // -----------------------------------------------------------------
    // bus idle at time zero
    // -----------------------------------------------------------------
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h00000000, 4'hF};
    end
    // write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] r, output bit tmo);
        bit pa, pw, pb;
        int n;
        @(posedge aclk);
        {pa, pw, pb} = 3'h7;
        r = 2'h3;
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        for (n = 0; n < 200 && (pa || pw || pb); n++) begin
            @(posedge aclk);
            if (pa && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a; // released lines do not keep the old value
                pa = 1'b0;
            end
            if (pw && wready) begin
                wvalid <= 1'b0;
                wdata <= ~d;
                pw = 1'b0;
            end
            if (pb && bvalid) begin
                bready <= 1'b0;
                r = bresp;
                pb = 1'b0;
            end
        end
        tmo = pa || pw || pb;
    endtask
    // read: address held until taken, rready held until data arrives
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r, output bit tmo);
        bit pa, pr;
        int n;
        @(posedge aclk);
        {pa, pr} = 2'h3;
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        for (n = 0; n < 200 && (pa || pr); n++) begin
            @(posedge aclk);
            if (pa && arready) begin
                arvalid <= 1'b0;
                araddr <= ~a;
                pa = 1'b0;
            end
            if (pr && rvalid) begin
                rready <= 1'b0;
                {d, r} = {rdata, rresp};
                pr = 1'b0;
            end
        end
        tmo = pa || pr;
    endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the flash command front end
// assumes the design package and the processor bus model are compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam logic [7:0] MD = efcui_pkg::OFF_MODE;
    localparam logic [7:0] CM = efcui_pkg::OFF_CMD;
    localparam logic [7:0] ST = efcui_pkg::OFF_STAT;
    localparam logic [31:0] FM = 32'h00100000;
    logic aclk, aresetn, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr, irq, sec;
    logic [7:0] awa, ara;
    logic [31:0] wd, rdat;
    logic [3:0] ws;
    logic [1:0] bresp, rresp, nvm;
    logic [2:0] rwc, wwc;
    int error_cnt, n_checks;
    // -----------------------------------------------------------------
    // design, bus model, clock
    // -----------------------------------------------------------------
    efcui_top #(.UNIT_TICKS(1)) i_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .irq(irq), .read_wait_cycles(rwc), .write_wait_cycles(wwc),
        .nvm_bits(nvm), .security_active(sec));
    efcui_cpu_model i_cpu (.aclk(aclk), .awaddr(awa), .awvalid(awv), .awready(awr),
        .wdata(wd), .wstrb(ws), .wvalid(wv), .wready(wrd), .bresp(bresp), .bvalid(bv),
        .bready(br), .araddr(ara), .arvalid(arv), .arready(arr), .rdata(rdat),
        .rresp(rresp), .rvalid(rv), .rready(rr));
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    // compare, report and close
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic limit_hit;
        error_cnt++;
        $display("Error %0t: wait limit used up", $time);
        results();
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        logic [1:0] r;
        bit t;
        i_cpu.wr(a, d, r, t);
        if (t) limit_hit();
        chk(32'(r), 32'(e), "write response");
    endtask
    task automatic bus_rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e);
        logic [31:0] d;
        logic [1:0] r;
        bit t;
        i_cpu.rd(a, d, r, t);
        if (t) limit_hit();
        chk(d, x, "read data");
        chk(32'(r), 32'(e), "read response");
    endtask
    // first poll must see busy, then poll until ready
    task automatic go_wait(input logic [31:0] c);
        logic [31:0] d;
        logic [1:0] r;
        bit t;
        int n;
        bus_wr(CM, c, 2'h0);
        i_cpu.rd(ST, d, r, t);
        if (t) limit_hit();
        chk(32'(d[0]), 0, "ready after start");
        for (n = 0; n < 400 && d[0] !== 1'b1; n++) i_cpu.rd(ST, d, r, t);
        if (t || d[0] !== 1'b1) limit_hit();
        chk(32'(r), 32'(efcui_pkg::RESP_OKAY), "poll response");
    endtask
    // page program is shorter once the erase step is skipped
    task automatic skip_erase_time;
        time t0, t1, t2;
        t0 = $time;
        go_wait(32'h5A000001);
        t1 = $time;
        bus_wr(MD, FM | 32'h88, 2'h0);
        t2 = $time;
        go_wait(32'h5A000001);
        chk(32'(($time - t2) < (t1 - t0)), 1, "skip erase time");
    endtask
    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        error_cnt = 0;
        n_checks = 0;
        aresetn = 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        bus_rd(MD, 32'h0, 2'h0);
        bus_rd(ST, 32'h1, 2'h0);
        bus_rd(CM, 32'h0, 2'h0);
        bus_rd(8'h70, 32'h0, 2'h2);
        bus_wr(8'h70, 32'h0, 2'h2);
        bus_wr(8'h6C, 32'hFFFFFFFF, 2'h0);
        bus_rd(8'h6C, 32'h0, 2'h0);
        bus_wr(MD, 32'hFFFFFFFF, 2'h0);
        bus_rd(MD, 32'h00FF038D, 2'h0);
        chk(32'(irq), 1, "ready interrupt");
        for (int w = 0; w < 4; w++) begin
            bus_wr(MD, FM | 32'(w << 8), 2'h0);
            chk(32'(rwc), w + 1, "read wait");
            chk(32'(wwc), (w < 2) ? w + 2 : 4, "write wait");
        end
        chk(32'(irq), 0, "masked");
        bus_wr(MD, FM | 32'h8, 2'h0);
        bus_wr(CM, 32'hA5000001, 2'h0);
        chk(32'(irq), 1, "error interrupt");
        bus_rd(ST, 32'h9, 2'h0);
        bus_rd(ST, 32'h1, 2'h0);
        chk(32'(irq), 0, "cleared");
        bus_wr(CM, 32'h5A000005, 2'h0);
        bus_rd(ST, 32'h9, 2'h0);
        bus_wr(CM, 32'h5A000000, 2'h0);
        bus_rd(ST, 32'h1, 2'h0);
        go_wait(32'h5A00C002);
        bus_rd(ST, 32'h00080001, 2'h0);
        bus_wr(MD, FM | 32'h4, 2'h0);
        bus_wr(CM, 32'h5A00C501, 2'h0);
        chk(32'(irq), 1, "lock error interrupt");
        bus_rd(ST, 32'h00080005, 2'h0);
        bus_rd(ST, 32'h00080001, 2'h0);
        bus_wr(CM, 32'h5A000008, 2'h0);
        bus_rd(ST, 32'h00080005, 2'h0);
        go_wait(32'h5A00FF04);
        bus_rd(ST, 32'h1, 2'h0);
        go_wait(32'h5A000008);
        go_wait(32'h5A014003);
        bus_rd(ST, 32'h00200001, 2'h0);
        bus_wr(CM, 32'h5A014004, 2'h0);
        go_wait(32'h5A000002);
        bus_rd(ST, 32'h1, 2'h0);
        go_wait(32'h5A00010B);
        chk(32'(nvm), 2, "nvm set");
        bus_rd(ST, 32'h201, 2'h0);
        go_wait(32'h5A00010D);
        chk(32'(nvm), 0, "nvm clear");
        go_wait(32'h5A00000F);
        chk(32'(sec), 1, "security");
        bus_rd(ST, 32'h11, 2'h0);
        skip_erase_time();
        results();
    end
endmodule
`default_nettype wire
